/* verilog/tei_pkg.sv */
/*
  tei_pkg: constants, register map and carrier structs for the transaction
  error and interrupt status block.
  assumes: one system clock; the transaction engine and the bus share it.
*/
`default_nettype none
package tei_pkg;

  // endpoint table size carried in the state struct
  localparam int unsigned EP_MAX      = 16;
  localparam int unsigned EP_W        = 4;
  localparam int unsigned TALLY_W     = 8;
  localparam int unsigned RETRY_W     = 4;
  localparam int unsigned LEN_W       = 16;
  localparam int unsigned PKT_W       = 8;

  // register byte offsets
  localparam logic [7:0] OFS_HOST_STATUS = 8'h00;
  localparam logic [7:0] OFS_INT_ENABLE  = 8'h04;
  localparam logic [7:0] OFS_MAX_RETRY   = 8'h08;
  localparam logic [7:0] OFS_TALLY_BASE  = 8'h40;

  // status and enable bit positions
  localparam int unsigned STS_DONE_BIT = 0;
  localparam int unsigned STS_ERR_BIT  = 1;
  localparam int unsigned STS_W        = 2;

  // reset values
  localparam logic [STS_W-1:0]   RST_STATUS    = 2'h0;
  localparam logic [STS_W-1:0]   RST_INT_EN    = 2'h0;
  localparam logic [RETRY_W-1:0] RST_MAX_RETRY = 4'h3;

  // endpoint transfer types
  typedef enum logic [1:0] {EP_CTRL, EP_BULK, EP_INTR, EP_ISOC} tei_ep_type_e;

  // transaction outcome as seen on the channel
  typedef enum logic [2:0] {
    RES_OK, RES_FCS, RES_TIMEOUT, RES_BAD_PID, RES_ACK
  } tei_result_e;

  // one finished transaction, presented for one cycle by the engine
  typedef struct packed {
    logic               valid;
    logic [EP_W-1:0]    ep;
    tei_ep_type_e       ep_type;
    logic               low_power;
    logic               is_in;
    tei_result_e        result;
    logic [PKT_W-1:0]   sent_mask;
    logic [PKT_W-1:0]   ack_code;
    logic [PKT_W-1:0]   stored_mask;
    logic               any_pkt_ok;
    logic               buf_fault;
    logic [LEN_W-1:0]   rx_bytes;
    logic [LEN_W-1:0]   total_bytes;
    logic [LEN_W-1:0]   max_pkt;
    logic               seg_mode;
    logic [LEN_W-1:0]   seg_len;
    logic               ioc;
    logic               complete;
  } tei_xact_s;

  // descriptor and handshake updates returned to the engine
  typedef struct packed {
    logic               valid;
    logic [EP_W-1:0]    ep;
    logic               is_in;
    logic               qh_overlength;
    logic               qh_clear_active;
    logic               qh_halted;
    logic               qh_buf_fault;
    logic               qh_retry_limit;
    logic               seg_overlength;
    logic               seg_clear_active;
    logic               writeback;
    logic [PKT_W-1:0]   ack_mask;
    logic               corrupt_tail;
    logic [LEN_W-1:0]   allowed_len;
  } tei_rsp_s;

  // whole state of the block
  typedef struct packed {
    logic [STS_W-1:0]                  sts;
    logic [STS_W-1:0]                  inten;
    logic [RETRY_W-1:0]                max_retry;
    logic [EP_MAX-1:0][TALLY_W-1:0]    tally;
    logic [EP_MAX-1:0][RETRY_W-1:0]    retries;
    logic [EP_MAX-1:0]                 prev_fail;
    tei_rsp_s                          rsp;
    logic                              ack;
    logic [31:0]                       rdata;
  } tei_state_s;

endpackage
`default_nettype wire

/* verilog/tei_core.sv */
/*
  tei_core: transaction error counting, babble and buffer fault handling,
  write-one-to-clear status with enables and one interrupt output, behind a
  classic wishbone slave.
  assumes: the transaction engine presents each result for one cycle on the
  system clock and acts on the response one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: writing one clears that status bit
// R2: clearing enable need not drop active interrupt
// R3: each transaction source has its enable bit
// R4: descriptor flag raises completion interrupt
// R5: per-endpoint retry count, zeroed on success
// R6: no retry limit for isochronous, low power
// R7: retry only if previous transaction fully failed
// R8: channel errors bump tally; limit sets flags
// R9: ack naming every sent packet is error
// R10: tally is running total, driver zeroes it
// R11: driver zeroes tally only when inactive
// R12: overlength sets flags, clears active, halts, writes back; code halts only non-isochronous endpoints
// R13: max length from type, total, packet size
// R14: babble sets error status, enable gates interrupt
// R15: isochronous oversize segment discarded alone
// R16: never send beyond length; babble only IN
// R17: buffer fault sets queue head flag
// R18: buffer fault bumps tally; limit gates interrupt
// R19: IN buffer fault withholds unstored packet acks
// R20: OUT buffer fault corrupts packet tail
// R21: interrupt while any enabled status bit set
module tei_core #(
  parameter int unsigned NUM_EP = 16
) (
  // clock and reset
  input  wire logic                I_CLK,
  input  wire logic                I_RESET_N,
  // wishbone slave
  input  wire logic                I_WB_CYC,
  input  wire logic                I_WB_STB,
  input  wire logic                I_WB_WE,
  input  wire logic [7:0]          I_WB_ADR,
  input  wire logic [3:0]          I_WB_SEL,
  input  wire logic [31:0]         I_WB_DAT,
  output logic [31:0]              O_WB_DAT,
  output logic                     O_WB_ACK,
  // transaction engine
  input  wire tei_pkg::tei_xact_s  I_XACT,
  output tei_pkg::tei_rsp_s        O_RSP,
  // interrupt
  output logic                     O_IRQ
);

  // refuse an endpoint count that the state struct cannot hold
  if (NUM_EP < 1 || NUM_EP > tei_pkg::EP_MAX) begin : g_bad_num_ep
    $error("NUM_EP out of range");
  end

  tei_pkg::tei_state_s st;
  tei_pkg::tei_state_s next_st;

  // decoded bus request
  logic                           req;
  logic                           wr;
  logic                           tally_hit;
  logic [tei_pkg::EP_W-1:0]       tally_idx;
  // event decode
  logic                           ev;
  logic                           iso;
  logic                           no_limit;
  logic                           err_ack;
  logic                           chan_err;
  logic                           fault;
  logic                           success;
  logic                           is_retry;
  logic [tei_pkg::RETRY_W-1:0]    cur_retries;
  logic                           at_max;
  logic [tei_pkg::LEN_W-1:0]      max_len;
  logic                           babble;
  logic                           seg_babble;
  logic [tei_pkg::STS_W-1:0]      sts_set;
  logic [tei_pkg::STS_W-1:0]      sts_clr;

  // bus decode, one wait state then ack
  assign req       = I_WB_CYC && I_WB_STB && !st.ack;
  assign wr        = req && I_WB_WE && I_WB_SEL[0];
  assign tally_hit = (I_WB_ADR >= tei_pkg::OFS_TALLY_BASE) &&
                     (I_WB_ADR[1:0] == 2'h0) &&
                     ({2'h0, I_WB_ADR[7:2]} - {2'h0, tei_pkg::OFS_TALLY_BASE[7:2]} < 8'(NUM_EP));
  assign tally_idx = tei_pkg::EP_W'(I_WB_ADR[7:2] - tei_pkg::OFS_TALLY_BASE[7:2]);

  // classify the finished transaction
  always_comb begin
    ev       = I_XACT.valid && (32'(I_XACT.ep) < NUM_EP);
    iso      = (I_XACT.ep_type == tei_pkg::EP_ISOC);
    no_limit = iso || I_XACT.low_power; // see R6
    // ack reporting every sent packet counts as a failure
    err_ack  = !I_XACT.is_in && (I_XACT.result == tei_pkg::RES_ACK) &&
               (I_XACT.sent_mask != 8'h00) &&
               ((I_XACT.ack_code & I_XACT.sent_mask) == I_XACT.sent_mask); // see R9
    chan_err = (I_XACT.result == tei_pkg::RES_FCS) ||
               (I_XACT.result == tei_pkg::RES_TIMEOUT) ||
               (I_XACT.result == tei_pkg::RES_BAD_PID) || err_ack; // see R8
    fault    = I_XACT.buf_fault; // see R17
    success  = I_XACT.any_pkt_ok && !chan_err && !fault;
    // a retry only when the last try to this endpoint moved nothing
    is_retry = st.prev_fail[I_XACT.ep]; // see R7
    cur_retries = st.retries[I_XACT.ep];
    at_max   = !no_limit && (cur_retries >= st.max_retry); // see R6
    // expected length by transfer type
    if (iso) begin
      max_len = I_XACT.max_pkt; // see R13
    end else if (I_XACT.total_bytes < I_XACT.max_pkt) begin
      max_len = I_XACT.total_bytes; // see R13
    end else begin
      max_len = I_XACT.max_pkt; // see R13
    end
    // babble is only judged on IN data
    babble     = I_XACT.is_in && !(iso && I_XACT.seg_mode) &&
                 (I_XACT.rx_bytes > max_len); // see R16
    seg_babble = I_XACT.is_in && iso && I_XACT.seg_mode &&
                 (I_XACT.rx_bytes > I_XACT.seg_len); // see R15
  end

  // status set and clear terms
  always_comb begin
    sts_set = '0;
    sts_clr = '0;
    if (ev && I_XACT.ioc && I_XACT.complete) begin
      sts_set[tei_pkg::STS_DONE_BIT] = 1'b1; // see R4
    end
    if (ev && (babble || seg_babble)) begin
      sts_set[tei_pkg::STS_ERR_BIT] = 1'b1; // see R14
    end
    if (ev && (chan_err || fault) && at_max) begin
      sts_set[tei_pkg::STS_ERR_BIT] = 1'b1; // see R8, see R18
    end
    if (wr && (I_WB_ADR == tei_pkg::OFS_HOST_STATUS)) begin
      sts_clr = I_WB_DAT[tei_pkg::STS_W-1:0]; // see R1
    end
  end

  // next state
  always_comb begin
    next_st = st;
    // set wins over a same-cycle clear
    next_st.sts = (st.sts & ~sts_clr) | sts_set; // see R1, see R2
    next_st.ack = req;
    next_st.rdata = 32'h0000_0000;
    if (wr && (I_WB_ADR == tei_pkg::OFS_INT_ENABLE)) begin
      next_st.inten = I_WB_DAT[tei_pkg::STS_W-1:0]; // see R3
    end
    if (wr && (I_WB_ADR == tei_pkg::OFS_MAX_RETRY)) begin
      next_st.max_retry = I_WB_DAT[tei_pkg::RETRY_W-1:0];
    end
    // driver zeroes a tally by writing its slot
    if (wr && tally_hit) begin
      next_st.tally[tally_idx] = '0; // see R10, see R11
    end
    // read mux; unmapped reads as zero
    if (req && !I_WB_WE) begin
      if (I_WB_ADR == tei_pkg::OFS_HOST_STATUS) begin
        next_st.rdata = 32'(st.sts);
      end else if (I_WB_ADR == tei_pkg::OFS_INT_ENABLE) begin
        next_st.rdata = 32'(st.inten);
      end else if (I_WB_ADR == tei_pkg::OFS_MAX_RETRY) begin
        next_st.rdata = 32'(st.max_retry);
      end else if (tally_hit) begin
        next_st.rdata = 32'(st.tally[tally_idx]);
      end
    end
    // per-endpoint counting
    if (ev) begin
      if (chan_err || fault) begin
        if (next_st.tally[I_XACT.ep] != '1) begin
          next_st.tally[I_XACT.ep] = next_st.tally[I_XACT.ep] + 1'b1; // see R8, see R18
        end
      end
      if (success) begin
        next_st.retries[I_XACT.ep]   = '0; // see R5
        next_st.prev_fail[I_XACT.ep] = 1'b0;
      end else if (!I_XACT.any_pkt_ok) begin
        next_st.prev_fail[I_XACT.ep] = 1'b1;
        if (is_retry && !no_limit && (cur_retries != '1)) begin
          next_st.retries[I_XACT.ep] = cur_retries + 1'b1; // see R5, see R7
        end
      end else begin
        next_st.prev_fail[I_XACT.ep] = 1'b0;
      end
    end
    // response to the engine
    next_st.rsp = '0;
    next_st.rsp.valid            = ev;
    next_st.rsp.ep               = I_XACT.ep;
    next_st.rsp.is_in            = I_XACT.is_in;
    next_st.rsp.allowed_len      = iso && I_XACT.seg_mode ? I_XACT.seg_len : max_len; // see R16
    next_st.rsp.ack_mask         = I_XACT.sent_mask;
    if (ev) begin
      if (babble) begin
        next_st.rsp.qh_overlength   = 1'b1; // see R12
        next_st.rsp.qh_clear_active = 1'b1; // see R12
        next_st.rsp.qh_halted       = !iso; // see R12
        next_st.rsp.writeback       = 1'b1; // see R12
      end
      if (seg_babble) begin
        next_st.rsp.seg_overlength   = 1'b1; // see R15
        next_st.rsp.seg_clear_active = 1'b1; // see R15
        next_st.rsp.writeback        = 1'b1;
      end
      if ((chan_err || fault) && at_max) begin
        next_st.rsp.qh_retry_limit = 1'b1; // see R8
        next_st.rsp.writeback      = 1'b1;
      end
      if (fault) begin
        next_st.rsp.qh_buf_fault = 1'b1; // see R17
        next_st.rsp.writeback    = 1'b1;
        if (I_XACT.is_in) begin
          next_st.rsp.ack_mask = I_XACT.sent_mask & I_XACT.stored_mask; // see R19
        end else begin
          next_st.rsp.corrupt_tail = 1'b1; // see R20
        end
      end
    end
  end

  // state register
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      st           <= '0;
      st.sts       <= tei_pkg::RST_STATUS;
      st.inten     <= tei_pkg::RST_INT_EN;
      st.max_retry <= tei_pkg::RST_MAX_RETRY;
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign O_WB_ACK = st.ack;
  assign O_WB_DAT = st.rdata;
  assign O_RSP    = st.rsp;
  assign O_IRQ    = |(st.sts & st.inten); // see R14, see R21

  a_sts_w1c: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // see R1
    (wr && I_WB_ADR == tei_pkg::OFS_HOST_STATUS && I_WB_DAT[tei_pkg::STS_DONE_BIT] &&
     !sts_set[tei_pkg::STS_DONE_BIT]) |=> !st.sts[tei_pkg::STS_DONE_BIT])
    else $error("status bit not cleared by write of one");

  a_ioc_done: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // see R4
    (ev && I_XACT.ioc && I_XACT.complete) |=> st.sts[tei_pkg::STS_DONE_BIT])
    else $error("completion flag did not raise status");

  a_babble_err: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // see R14
    (ev && babble) |=> (st.sts[tei_pkg::STS_ERR_BIT] && st.rsp.qh_overlength))
    else $error("babble did not set error status");

  a_retry_zero: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // see R5
    (ev && success) |=> (st.retries[$past(I_XACT.ep)] == '0))
    else $error("retry count not zeroed on success");

  a_iso_nolimit: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // see R6
    (ev && no_limit) |=> !st.rsp.qh_retry_limit)
    else $error("retry limit applied to exempt endpoint");

  a_tally_step: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // see R8
    (ev && (chan_err || fault) && !(wr && tally_hit) && st.tally[I_XACT.ep] != '1)
    |=> (st.tally[$past(I_XACT.ep)] == $past(st.tally[I_XACT.ep]) + 1'b1))
    else $error("tally did not step by one");

  a_babble_halt: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // see R12
    (ev && babble && !iso) |=> (st.rsp.qh_halted && st.rsp.qh_clear_active &&
                                st.rsp.writeback))
    else $error("overlength did not halt endpoint");

  a_seg_alone: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // see R15
    st.rsp.seg_overlength |-> (st.rsp.seg_clear_active && !st.rsp.qh_clear_active))
    else $error("segment babble touched queue head active");

  a_out_corrupt: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // see R20
    (st.rsp.qh_buf_fault && !st.rsp.is_in) |-> st.rsp.corrupt_tail)
    else $error("out buffer fault did not corrupt tail");

  a_irq_hold: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // see R21
    ($rose(st.sts[tei_pkg::STS_ERR_BIT]) && st.inten[tei_pkg::STS_ERR_BIT] &&
     $stable(st.inten)) |-> O_IRQ)
    else $error("interrupt not raised for enabled status");

  a_limit_flags: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // see R8
    (ev && (chan_err || fault) && !no_limit && st.retries[I_XACT.ep] >= st.max_retry)
    |=> (st.rsp.qh_retry_limit && st.sts[tei_pkg::STS_ERR_BIT]))
    else $error("retry limit did not raise flags");

  a_below_limit: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // see R18
    (ev && st.retries[I_XACT.ep] < st.max_retry) |=> !st.rsp.qh_retry_limit)
    else $error("retry limit flagged below maximum");

  a_retry_hold: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // see R7
    (ev && !I_XACT.any_pkt_ok && !st.prev_fail[I_XACT.ep])
    |=> (st.retries[$past(I_XACT.ep)] == $past(st.retries[I_XACT.ep])))
    else $error("retry counted after a partly good transaction");

  a_len_bound: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // see R13
    (ev && !iso) |=> (st.rsp.allowed_len <= $past(I_XACT.max_pkt) &&
                      st.rsp.allowed_len <= $past(I_XACT.total_bytes)))
    else $error("allowed length above total or packet size");

  a_in_only_babble: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // see R16
    (ev && !I_XACT.is_in) |=> !(st.rsp.qh_overlength || st.rsp.seg_overlength))
    else $error("overlength flagged on outgoing data");

  a_fault_flag: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // see R17
    (ev && fault) |=> (st.rsp.qh_buf_fault && st.rsp.writeback))
    else $error("buffer fault not flagged in queue head");

  a_in_fault_ack: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // see R19
    (ev && fault && I_XACT.is_in) |=>
    (st.rsp.ack_mask == ($past(I_XACT.sent_mask) & $past(I_XACT.stored_mask))))
    else $error("unstored packet acknowledged after fault");

endmodule
`default_nettype wire

/* test/tei_link_model.sv */
/*
  tei_link_model: far-side devices as seen by the transaction engine.
  assumes: the bench hands over one finished transaction with i_go high
  for one cycle; the core samples it at the next rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module tei_link_model (
  // request from the bench
  input  wire logic               i_go,
  input  wire tei_pkg::tei_xact_s i_req,
  // toward the core
  output tei_pkg::tei_xact_s      o_xact
);
  // idle cycles show an inverted pattern, never the last transfer
  always_comb begin
    o_xact       = i_go ? i_req : ~i_req;
    o_xact.valid = i_go;
    if (i_go && !i_req.is_in) begin
      o_xact.rx_bytes = 16'h0000;  // devices only babble on IN
    end
  end
endmodule
`default_nettype wire

/* test/test_tei_core.sv */
/*
  test_tei_core: directed and random transactions with register checks.
  assumes: tei_pkg, tei_core and tei_link_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module test_tei_core;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               cyc = 1'b0;
  logic               stb = 1'b0;
  logic               we = 1'b0;
  logic               go = 1'b0;
  logic [7:0]         adr = 8'h00;
  logic [3:0]         sel = 4'h0;
  logic [31:0]        wdat = 32'h0;
  logic [31:0]        rd, rdat;
  logic               ack, irq;
  tei_pkg::tei_xact_s req = '0;
  tei_pkg::tei_xact_s xact, t;
  tei_pkg::tei_rsp_s  rsp, e;
  logic [15:0]        lf = 16'h5F0D;
  logic [15:0]        r;
  logic [7:0]         tally [16];
  logic [3:0]         retr [16];
  logic               prevf [16];
  logic [1:0]         sts = 2'h0;
  logic [1:0]         en = 2'h0;
  logic [3:0]         maxr = 4'h3;
  int                 n_errors = 0;
  int                 checked = 0;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  tei_link_model tei_link_model_i (.i_go(go), .i_req(req), .o_xact(xact));
  tei_core tei_core_i (.I_CLK(clk), .I_RESET_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat),
    .O_WB_ACK(ack), .I_XACT(xact), .O_RSP(rsp), .O_IRQ(irq));

  // verdict and end of run
  task automatic wrap_up();
    if (n_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // pseudo random source
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction

  // one classic wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hF);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      wrap_up();
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // read a register and compare
  task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
    wb(1'b0, a, 32'h0);
    `CHK("register", x, rd)
  endtask

  // channel error, error ack included
  function automatic logic cerr(input tei_pkg::tei_xact_s q);
    return q.result inside {tei_pkg::RES_FCS, tei_pkg::RES_TIMEOUT, tei_pkg::RES_BAD_PID}
      || (q.result == tei_pkg::RES_ACK && !q.is_in && q.sent_mask != 8'h00
          && (q.ack_code & q.sent_mask) == q.sent_mask);
  endfunction

  // flag view of a response
  function automatic logic [14:0] flags(input tei_pkg::tei_rsp_s q);
    return {q.valid, q.ep, q.is_in, q.qh_overlength, q.qh_clear_active, q.qh_halted,
            q.qh_buf_fault, q.qh_retry_limit, q.seg_overlength, q.seg_clear_active,
            q.writeback, q.corrupt_tail};
  endfunction

  // expected response and state update
  task automatic predict(input tei_pkg::tei_xact_s q);
    logic er, ex, iso, bab;
    logic [15:0] ml;
    iso = q.ep_type == tei_pkg::EP_ISOC;
    er = cerr(q) | q.buf_fault;
    ex = iso | q.low_power;
    ml = (iso || q.max_pkt < q.total_bytes) ? q.max_pkt : q.total_bytes;
    bab = q.is_in && !(iso && q.seg_mode) && q.rx_bytes > ml;
    e = '0;
    e.valid = 1'b1;
    e.ep = q.ep;
    e.is_in = q.is_in;
    e.allowed_len = (iso && q.seg_mode) ? q.seg_len : ml;
    e.ack_mask = (q.is_in && q.buf_fault) ? (q.sent_mask & q.stored_mask) : q.sent_mask;
    e.qh_retry_limit = er && !ex && retr[q.ep] >= maxr;
    if (er && tally[q.ep] != 8'hFF) tally[q.ep]++;
    if (q.any_pkt_ok && !er) retr[q.ep] = 4'h0;
    else if (!q.any_pkt_ok && prevf[q.ep] && !ex && retr[q.ep] != 4'hF) retr[q.ep]++;
    prevf[q.ep] = !q.any_pkt_ok;
    {e.qh_overlength, e.qh_clear_active} = {2{bab}};
    e.qh_halted = bab && !iso;
    e.seg_overlength = q.is_in && iso && q.seg_mode && q.rx_bytes > q.seg_len;
    e.seg_clear_active = e.seg_overlength;
    e.qh_buf_fault = q.buf_fault;
    e.corrupt_tail = q.buf_fault && !q.is_in;
    e.writeback = bab | e.seg_overlength | e.qh_retry_limit | q.buf_fault;
    if (e.qh_retry_limit || bab || e.seg_overlength) sts[1] = 1'b1;
    if (q.ioc && q.complete) sts[0] = 1'b1;
  endtask

  // hand one transaction over and check the answer
  task automatic send(input tei_pkg::tei_xact_s q);
    q.any_pkt_ok = !(cerr(q) | q.buf_fault);
    @(posedge clk);
    req <= q;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    predict(q);
    @(negedge clk);
    `CHK("rsp flags", flags(e), flags(rsp))
    `CHK("allowed", e.allowed_len, rsp.allowed_len)
    `CHK("ack mask", e.ack_mask, rsp.ack_mask)
    `CHK("irq", |(sts & en), irq)
    rdchk(tei_pkg::OFS_TALLY_BASE + {2'b00, q.ep, 2'b00}, {24'h0, tally[q.ep]});
  endtask

  // random transaction
  function automatic tei_pkg::tei_xact_s gen();
    tei_pkg::tei_xact_s q;
    logic [15:0] a, b;
    a = rnd();
    b = rnd();
    q = '0;
    q.ep = a[3:0];
    q.ep_type = tei_pkg::tei_ep_type_e'(a[5:4]);
    q.low_power = a[6] & a[7];
    q.is_in = a[8];
    q.result = tei_pkg::tei_result_e'(a[11:9] % 3'h5);
    q.sent_mask = b[7:0];
    q.ack_code = a[12] ? b[7:0] : b[15:8];
    q.stored_mask = b[15:8];
    q.buf_fault = a[15:13] == 3'h0;
    q.total_bytes = {8'h00, b[15:8]};
    q.max_pkt = 16'h0040;
    q.seg_mode = a[9];
    q.seg_len = 16'h0020;
    q.rx_bytes = {10'h000, b[13:8]} + 16'h0010;
    {q.ioc, q.complete} = b[1:0];
    return q;
  endfunction

  // watchdog
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    wrap_up();
  end

  // main sequence
  initial begin
    for (int i = 0; i < 16; i++) begin
      {tally[i], retr[i], prevf[i]} = '0;
    end
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(tei_pkg::OFS_HOST_STATUS, 32'h0);
    rdchk(tei_pkg::OFS_MAX_RETRY, 32'h3);
    rdchk(8'h20, 32'h0);
    wb(1'b1, tei_pkg::OFS_INT_ENABLE, 32'h3, 4'hE);
    rdchk(tei_pkg::OFS_INT_ENABLE, 32'h0);
    wb(1'b1, tei_pkg::OFS_INT_ENABLE, 32'h2);
    en = 2'h2;
    // consecutive failures on one bulk endpoint, then success
    t = '0;
    t.ep = 4'h5;
    t.ep_type = tei_pkg::EP_BULK;
    t.result = tei_pkg::RES_FCS;
    t.total_bytes = 16'h0010;
    t.max_pkt = 16'h0040;
    repeat (6) send(t);
    t.result = tei_pkg::RES_OK;
    send(t);
    t.result = tei_pkg::RES_ACK;
    t.sent_mask = 8'h0F;
    t.ack_code = 8'h0F;
    repeat (5) send(t);
    t.ack_code = 8'h07;
    send(t);
    // exempt endpoints never reach the limit
    t.result = tei_pkg::RES_TIMEOUT;
    t.low_power = 1'b1;
    repeat (6) send(t);
    t.ep_type = tei_pkg::EP_ISOC;
    t.low_power = 1'b0;
    repeat (6) send(t);
    // babble, segment babble, buffer faults, completion
    t.result = tei_pkg::RES_OK;
    t.is_in = 1'b1;
    t.rx_bytes = 16'h0021;
    t.seg_mode = 1'b1;
    t.seg_len = 16'h0020;
    send(t);
    t.ep_type = tei_pkg::EP_BULK;
    t.seg_mode = 1'b0;
    t.rx_bytes = 16'h0011;
    send(t);
    t.rx_bytes = 16'h0010;
    t.buf_fault = 1'b1;
    t.stored_mask = 8'h03;
    send(t);
    t.is_in = 1'b0;
    send(t);
    t.buf_fault = 1'b0;
    {t.ioc, t.complete} = 2'h3;
    wb(1'b1, tei_pkg::OFS_INT_ENABLE, 32'h1);
    en = 2'h1;
    send(t);
    rdchk(tei_pkg::OFS_HOST_STATUS, {30'h0, sts});
    wb(1'b1, tei_pkg::OFS_HOST_STATUS, 32'h3);
    sts = 2'h0;
    rdchk(tei_pkg::OFS_HOST_STATUS, 32'h0);
    `CHK("irq clear", 1'b0, irq)
    // random traffic with a low retry limit
    wb(1'b1, tei_pkg::OFS_MAX_RETRY, 32'h1);
    maxr = 4'h1;
    wb(1'b1, tei_pkg::OFS_INT_ENABLE, 32'h3);
    en = 2'h3;
    repeat (300) begin
      send(gen());
      r = rnd();
      if (r[2:0] == 3'h0) begin
        rdchk(tei_pkg::OFS_HOST_STATUS, {30'h0, sts});
        wb(1'b1, tei_pkg::OFS_HOST_STATUS, {30'h0, r[4:3]});
        sts = sts & ~r[4:3];
      end
    end
    // no traffic in flight: tallies may be zeroed
    for (int i = 0; i < 16; i++) begin
      wb(1'b1, tei_pkg::OFS_TALLY_BASE + 8'(4 * i), 32'h0);
      rdchk(tei_pkg::OFS_TALLY_BASE + 8'(4 * i), 32'h0);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
